// >>> common/srrp_pkg.sv
// Constants and types for the shared register read return path
// Notes on behaviour
// - Four-bit slice codes select every slice operation
// - Four parity bits checked per register read
// - Parity mismatch returns code 03, data still sent
// - Address register write forwards no code
// - Fast command only on illegal return steering
// - Broadside read returns all 64 semaphores
// - Slice data moves on even phases
// - Data enters buffer B, then buffer A
// - Steering bit 2 dropped at distributors
// - Code bit 3 rebuilds command bits 5:4
// - Ten holding buffers, two round-robin groups
// - Holding buffer groups alternate grants
// - Steering bits 1 and 4 pick path
// - Local word sent as two halves
// - Remote word rebuilt before return
// - Steering bits 0 and 3 pick CPU
// - Return port rotates remote, fast, local
// - CPU gets 32 bits per even phase
// - Test-and-set table entry per CPU
// - Code 14 loads entry and sets pending
// - CPUs grouped in fours, lower and upper sets
// - First level rotates, ascending start
// - Second level rotates, third alternates
// - Set semaphore retries; clear returns one
package srrp_pkg;
    // ==========================================
    // Sizes
    localparam int unsigned NCPU = 32;
    localparam int unsigned NSLICE = 10;
    localparam int unsigned FIFO_DEPTH = 16;
    // ==========================================
    // Slice operation codes
    localparam logic [3:0] OP_SB_RD_INC = 4'h1;
    localparam logic [3:0] OP_SB_RD = 4'h2;
    localparam logic [3:0] OP_PAR_ERR = 4'h3;
    localparam logic [3:0] OP_ST_RD = 4'h4;
    localparam logic [3:0] OP_ST_WR = 4'h5;
    localparam logic [3:0] OP_DEADLOCK = 4'h6;
    localparam logic [3:0] OP_ATTACH = 4'h7;
    localparam logic [3:0] OP_SM_BRD_RD = 4'h9;
    localparam logic [3:0] OP_SM_BRD_WR = 4'hb;
    localparam logic [3:0] OP_TEST_SET = 4'hc;
    localparam logic [3:0] OP_FLUSH = 4'hd;
    localparam logic [3:0] OP_SM_CLR = 4'he;
    localparam logic [3:0] OP_SM_SET = 4'hf;
    // ==========================================
    // Command rebuild prefixes (bits 5:4)
    localparam logic [1:0] CMD_HI_40 = 2'h2;
    localparam logic [1:0] CMD_HI_30 = 2'h1;
    // ==========================================
    // Reset values and return sources
    localparam logic [2:0] RR_INIT = 3'h0;
    localparam logic [1:0] SRC_REMOTE = 2'h0;
    localparam logic [1:0] SRC_FAST = 2'h1;
    localparam logic [1:0] SRC_LOCAL = 2'h2;
    localparam logic [63:0] TS_OK_WORD = 64'h1;
    // Output serializer states
    typedef enum logic [1:0] {
        OUT_IDLE = 2'b00,
        OUT_LO = 2'b01,
        OUT_HI = 2'b11
    } out_state_e;
endpackage

// >>> verilog/srrp_fifo.sv
// Flop-based FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module srrp_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 16
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data,
    output logic [$clog2(D):0] o_count
);
    localparam int unsigned AW = $clog2(D);
    initial begin
        if (D < 2 || (1 << AW) != D) $error("FIFO depth must be a power of two");
    end
    logic [W-1:0] mem [D]; // Storage
    logic [AW-1:0] wp; // Write index
    logic [AW-1:0] rp; // Read index
    logic push;
    logic pop;
    assign push = i_valid & o_ready;
    assign pop = o_valid & i_ready;
    assign o_data = mem[rp];
    // Storage write
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wp] <= i_data;
        end
    end
    // Pointers, count, full and empty flags
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp <= '0;
            rp <= '0;
            o_count <= '0;
            o_ready <= 1'b1;
            o_valid <= 1'b0;
        end else begin
            if (push) wp <= wp + 1'b1;
            if (pop) rp <= rp + 1'b1;
            if (push && !pop) begin
                o_count <= o_count + 1'b1;
                o_ready <= (o_count != (AW+1)'(D - 1));
                o_valid <= 1'b1;
            end else if (pop && !push) begin
                o_count <= o_count - 1'b1;
                o_ready <= 1'b1;
                o_valid <= (o_count != (AW+1)'(1));
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/shared_register_read_return_path.sv
// Read return and test-and-set front end of the shared register module
`timescale 1ns/1ps
`default_nettype none
module shared_register_read_return_path #(
    parameter logic [3:0] SLICE_ID = 4'h0 // Index of this register slice
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Register slice operations
    input wire logic i_op_valid,
    output logic o_op_ready,
    input wire logic [3:0] i_op_code,
    input wire logic [4:0] i_op_cpu,
    input wire logic [3:0] i_op_slice,
    input wire logic [63:0] i_op_data,
    input wire logic [3:0] i_op_par,
    input wire logic [5:0] i_op_sem,
    input wire logic i_op_cluster,
    input wire logic i_op_mm,
    input wire logic i_op_illegal,
    // Remote return path input
    input wire logic i_rmt_valid,
    output logic o_rmt_ready,
    input wire logic [63:0] i_rmt_data,
    input wire logic [5:0] i_rmt_cmd,
    input wire logic [3:0] i_rmt_steer,
    // CPU return port output
    output logic o_ret_valid,
    output logic o_ret_last,
    output logic [31:0] o_ret_data,
    output logic [5:0] o_ret_cmd,
    output logic [1:0] o_ret_cpu,
    output logic [1:0] o_ret_path
);
    import srrp_pkg::*;
    initial begin
        if (SLICE_ID >= 4'(NSLICE)) $error("SLICE_ID out of range");
    end

    // ==========================================
    // Helpers
    // Rotating pick: first request at or after ptr, found flag on top
    function automatic logic [3:0] rr_pick(logic [7:0] req, logic [2:0] ptr, int n);
        logic [3:0] r;
        int k;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            k = (int'(ptr) + i) % n;
            if (i < n && req[k]) r = {1'b1, 3'(k)};
        end
        return r;
    endfunction
    // Pointer after a grant: winner drops to lowest priority
    function automatic logic [2:0] rr_next(logic [2:0] idx, int n);
        return (int'(idx) == n - 1) ? 3'h0 : idx + 3'h1;
    endfunction
    // Command rebuilt from slice code
    function automatic logic [5:0] cmd6(logic [3:0] code);
        return {code[3] ? CMD_HI_30 : CMD_HI_40, code};
    endfunction
    // Distributors keep steering bits 4,3,1,0 only
    function automatic logic [3:0] steer4(logic [4:0] s);
        return {s[4], s[3], s[1], s[0]};
    endfunction

    // ==========================================
    // Even phase enable
    logic phase; // Low on even phases
    logic even;
    assign even = ~phase;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) phase <= 1'b0;
        else phase <= ~phase;
    end

    // ==========================================
    // Slice decode and parity
    logic acc; // Operation taken
    logic is_rd; // Address or scalar register read
    logic is_bsr; // Broadside semaphore read
    logic mism; // Any parity mismatch
    logic push_op;
    logic [3:0] op_code_out;
    logic [63:0] op_data_out;
    logic [63:0] sem [2]; // Semaphores of both clusters
    logic [3:0] par;
    assign acc = i_op_valid & o_op_ready;
    assign is_rd = (i_op_code == OP_SB_RD_INC) || (i_op_code == OP_SB_RD) ||
                   (i_op_code == OP_ST_RD);
    assign is_bsr = (i_op_code == OP_SM_BRD_RD);
    // One parity bit per 16-bit block of each storage array
    always_comb begin
        for (int k = 0; k < 4; k++) par[k] = ^i_op_data[16*k +: 16];
    end
    assign mism = (par != i_op_par);
    // Writes (codes 03 and 05) never reach the distributors
    assign push_op = acc & (is_rd | is_bsr) & ~i_op_illegal;
    assign op_code_out = is_bsr ? OP_SM_BRD_RD : (mism ? OP_PAR_ERR : i_op_code);
    assign op_data_out = is_bsr ? sem[i_op_cluster] : i_op_data;

    // ==========================================
    // Test-and-set table and selection
    logic [NCPU-1:0] ts_mm, ts_cl0, ts_cl1, ts_pend0, ts_pend1;
    logic [5:0] ts_sem [NCPU]; // Semaphore number per CPU
    logic [1:0] p1 [8]; // First-level pointers
    logic [1:0] p2 [2]; // Second-level pointers
    logic p3; // Third level: set with priority
    logic [NCPU-1:0] ts_req;
    logic [1:0] g1 [8];
    logic [7:0] any1;
    logic [1:0] g2 [2];
    logic [1:0] any2;
    logic ts_set;
    logic [4:0] ts_cpu;
    logic ts_cl;
    logic ts_go;
    logic ts_ok;
    logic [3:0] t;
    logic fifo_in_ready;
    // Eligible when attached to that cluster or in monitor mode
    assign ts_req = (ts_pend0 & (ts_cl0 | ts_mm)) | (ts_pend1 & (ts_cl1 | ts_mm));
    always_comb begin
        for (int g = 0; g < 8; g++) begin
            t = rr_pick({4'h0, ts_req[4*g +: 4]}, {1'b0, p1[g]}, 4);
            any1[g] = t[3];
            g1[g] = t[1:0];
        end
        for (int s = 0; s < 2; s++) begin
            t = rr_pick({4'h0, any1[4*s +: 4]}, {1'b0, p2[s]}, 4);
            any2[s] = t[3];
            g2[s] = t[1:0];
        end
        ts_set = any2[p3] ? p3 : ~p3;
    end
    assign ts_cpu = {ts_set, g2[ts_set], g1[{ts_set, g2[ts_set]}]};
    assign ts_cl = ~(ts_pend0[ts_cpu] & (ts_cl0[ts_cpu] | ts_mm[ts_cpu]));
    assign ts_go = (|any2) & ~acc & fifo_in_ready;
    assign ts_ok = ~sem[ts_cl][ts_sem[ts_cpu]];

    // Table, priorities and semaphore state
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ts_mm <= '0;
            ts_cl0 <= '0;
            ts_cl1 <= '0;
            ts_pend0 <= '0;
            ts_pend1 <= '0;
            for (int i = 0; i < NCPU; i++) ts_sem[i] <= '0;
            for (int g = 0; g < 8; g++) p1[g] <= RR_INIT[1:0];
            p2[0] <= RR_INIT[1:0];
            p2[1] <= RR_INIT[1:0];
            p3 <= 1'b0;
            sem[0] <= '0;
            sem[1] <= '0;
        end else begin
            // Granted request: rotate all three levels
            if (ts_go) begin
                p1[{ts_set, g2[ts_set]}] <= 2'(rr_next({1'b0, ts_cpu[1:0]}, 4));
                p2[ts_set] <= 2'(rr_next({1'b0, g2[ts_set]}, 4));
                p3 <= ~ts_set;
                if (ts_ok) begin
                    sem[ts_cl][ts_sem[ts_cpu]] <= 1'b1;
                    if (ts_cl) ts_pend1[ts_cpu] <= 1'b0;
                    else ts_pend0[ts_cpu] <= 1'b0;
                end
            end
            // Slice operations that touch the table or semaphores
            if (acc) begin
                case (i_op_code)
                    OP_ATTACH: begin
                        ts_mm[i_op_cpu] <= i_op_mm;
                        if (i_op_cluster) ts_cl1[i_op_cpu] <= 1'b1;
                        else ts_cl0[i_op_cpu] <= 1'b1;
                    end
                    OP_TEST_SET: begin
                        ts_sem[i_op_cpu] <= i_op_sem;
                        if (i_op_cluster) ts_pend1[i_op_cpu] <= 1'b1;
                        else ts_pend0[i_op_cpu] <= 1'b1;
                    end
                    OP_SM_CLR: sem[i_op_cluster][i_op_sem] <= 1'b0;
                    OP_SM_SET: sem[i_op_cluster][i_op_sem] <= 1'b1;
                    OP_SM_BRD_WR: sem[i_op_cluster] <= i_op_data;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Slice to distributor FIFO
    localparam int unsigned FW = 76; // {slice, steer, code, data}
    logic push;
    logic [FW-1:0] fifo_in;
    logic fifo_ov;
    logic fifo_or;
    logic [FW-1:0] fifo_out;
    logic [$clog2(FIFO_DEPTH):0] fifo_cnt;
    assign push = push_op | (ts_go & ts_ok);
    assign fifo_in = push_op ? {i_op_slice, steer4(i_op_cpu), op_code_out, op_data_out} :
                     {SLICE_ID, steer4(ts_cpu), OP_TEST_SET, TS_OK_WORD};
    srrp_fifo #(.W(FW), .D(FIFO_DEPTH)) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_valid(push),
        .o_ready(fifo_in_ready),
        .i_data(fifo_in),
        .o_valid(fifo_ov),
        .i_ready(fifo_or),
        .o_data(fifo_out),
        .o_count(fifo_cnt)
    );

    // ==========================================
    // Fast response for illegal steering
    logic fast_v;
    logic [5:0] fast_cmd;
    logic [3:0] fast_steer;
    logic next_fast_v;
    logic [1:0] pick;
    logic out_take;
    assign next_fast_v = (fast_v & ~(out_take & pick == SRC_FAST)) |
                         (acc & (is_rd | is_bsr) & i_op_illegal);
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fast_v <= 1'b0;
            fast_cmd <= '0;
            fast_steer <= '0;
        end else begin
            fast_v <= next_fast_v;
            if (acc & i_op_illegal) begin
                fast_cmd <= cmd6(i_op_code);
                fast_steer <= steer4(i_op_cpu);
            end
        end
    end
    // Ready holds slack for one push while the flag is registered
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) o_op_ready <= 1'b0;
        else o_op_ready <= (fifo_cnt < ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - 2)) & ~next_fast_v;
    end

    // ==========================================
    // Distributor input buffers B then A
    logic b_v, a_v;
    logic [3:0] b_slice, a_slice;
    logic [3:0] b_steer, a_steer;
    logic [5:0] b_cmd, a_cmd;
    logic [63:0] b_data, a_data;
    logic take_b;
    logic a_leave;
    logic [NSLICE-1:0] hb_v;
    assign take_b = b_v & ~a_v;
    assign fifo_or = even & (~b_v | take_b);
    assign a_leave = a_v & ((a_slice >= 4'(NSLICE)) || !hb_v[a_slice]);
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            b_v <= 1'b0;
            a_v <= 1'b0;
            {b_slice, b_steer, b_cmd, b_data} <= '0;
            {a_slice, a_steer, a_cmd, a_data} <= '0;
        end else begin
            if (take_b) b_v <= 1'b0;
            if (fifo_ov & fifo_or) begin
                b_v <= 1'b1;
                b_slice <= fifo_out[75:72];
                b_steer <= fifo_out[71:68];
                b_cmd <= cmd6(fifo_out[67:64]);
                b_data <= fifo_out[63:0];
            end
            if (a_leave) a_v <= 1'b0;
            if (take_b) begin
                a_v <= 1'b1;
                {a_slice, a_steer, a_cmd, a_data} <= {b_slice, b_steer, b_cmd, b_data};
            end
        end
    end

    // ==========================================
    // Output holding buffers, two groups of five
    logic [3:0] hb_steer [NSLICE];
    logic [5:0] hb_cmd [NSLICE];
    logic [63:0] hb_data [NSLICE];
    logic [2:0] pa, pb; // Group pointers
    logic grp_turn; // Group with priority
    logic [3:0] ra, rb;
    logic sel_b;
    logic [3:0] loc_idx;
    assign ra = rr_pick({3'h0, hb_v[4:0]}, pa, 5);
    assign rb = rr_pick({3'h0, hb_v[9:5]}, pb, 5);
    assign sel_b = grp_turn ? rb[3] : ~ra[3];
    assign loc_idx = sel_b ? 4'(rb[2:0]) + 4'h5 : {1'b0, ra[2:0]};
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hb_v <= '0;
            pa <= RR_INIT;
            pb <= RR_INIT;
            grp_turn <= 1'b0;
            for (int i = 0; i < NSLICE; i++) begin
                hb_steer[i] <= '0;
                hb_cmd[i] <= '0;
                hb_data[i] <= '0;
            end
        end else begin
            if (out_take && pick == SRC_LOCAL) begin
                hb_v[loc_idx] <= 1'b0;
                grp_turn <= ~sel_b;
                if (sel_b) pb <= rr_next(rb[2:0], 5);
                else pa <= rr_next(ra[2:0], 5);
            end
            if (a_leave && a_slice < 4'(NSLICE)) begin
                hb_v[a_slice] <= 1'b1;
                hb_steer[a_slice] <= a_steer;
                hb_cmd[a_slice] <= a_cmd;
                hb_data[a_slice] <= a_data;
            end
        end
    end

    // ==========================================
    // Remote return holding register
    logic [63:0] rmt_data;
    logic [5:0] rmt_cmd;
    logic [3:0] rmt_steer;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rmt_ready <= 1'b1;
            rmt_data <= '0;
            rmt_cmd <= '0;
            rmt_steer <= '0;
        end else if (i_rmt_valid && o_rmt_ready) begin
            o_rmt_ready <= 1'b0;
            rmt_data <= i_rmt_data;
            rmt_cmd <= i_rmt_cmd;
            rmt_steer <= i_rmt_steer;
        end else if (out_take && pick == SRC_REMOTE) begin
            o_rmt_ready <= 1'b1;
        end
    end

    // ==========================================
    // CPU return port arbitration and serializer
    logic [2:0] p_ret; // Return source pointer
    logic [2:0] req3;
    logic [3:0] r3;
    logic [63:0] src_data, word;
    logic [5:0] src_cmd;
    logic [3:0] src_steer;
    out_state_e ost;
    assign req3 = {(ra[3] | rb[3]), fast_v, ~o_rmt_ready};
    assign r3 = rr_pick({5'h0, req3}, p_ret, 3);
    assign pick = r3[1:0];
    assign out_take = (ost == OUT_IDLE) & r3[3];
    always_comb begin
        case (pick)
            SRC_REMOTE: {src_data, src_cmd, src_steer} = {rmt_data, rmt_cmd, rmt_steer};
            SRC_FAST: {src_data, src_cmd, src_steer} = {64'h0, fast_cmd, fast_steer};
            default: begin
                src_data = hb_data[loc_idx];
                src_cmd = hb_cmd[loc_idx];
                src_steer = hb_steer[loc_idx];
            end
        endcase
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ost <= OUT_IDLE;
            p_ret <= RR_INIT;
            word <= '0;
            o_ret_valid <= 1'b0;
            o_ret_last <= 1'b0;
            o_ret_data <= '0;
            o_ret_cmd <= '0;
            o_ret_cpu <= '0;
            o_ret_path <= '0;
        end else begin
            o_ret_valid <= 1'b0;
            case (ost)
                OUT_IDLE: begin
                    if (out_take) begin
                        p_ret <= rr_next({1'b0, pick}, 3);
                        word <= src_data;
                        o_ret_cmd <= src_cmd;
                        o_ret_cpu <= {src_steer[2], src_steer[0]};
                        o_ret_path <= {src_steer[3], src_steer[1]};
                        ost <= OUT_LO;
                    end
                end
                OUT_LO: begin
                    if (even) begin
                        o_ret_valid <= 1'b1;
                        o_ret_last <= 1'b0;
                        o_ret_data <= word[31:0];
                        ost <= OUT_HI;
                    end
                end
                OUT_HI: begin
                    if (even) begin
                        o_ret_valid <= 1'b1;
                        o_ret_last <= 1'b1;
                        o_ret_data <= word[63:32];
                        ost <= OUT_IDLE;
                    end
                end
                default: ost <= OUT_IDLE;
            endcase
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    a_parity_err_code: assert property (acc && is_rd && mism && !i_op_illegal |->
        push && fifo_in[67:64] == OP_PAR_ERR) else $error("parity error code missing");
    a_write_no_fwd: assert property (acc && (i_op_code == OP_PAR_ERR ||
        i_op_code == OP_ST_WR) |-> !push_op) else $error("write forwarded");
    a_fast_only_illegal: assert property ($rose(fast_v) |-> $past(acc && i_op_illegal))
        else $error("fast response without illegal steering");
    a_ret_two_halves: assert property (o_ret_valid && !o_ret_last |->
        ##2 o_ret_valid && o_ret_last) else $error("second half not on next even");
    a_cmd_rebuild: assert property (b_v |-> b_cmd[5:4] ==
        (b_cmd[3] ? CMD_HI_30 : CMD_HI_40)) else $error("command prefix wrong");
    // Winner's pending bit of its own cluster is gone and its semaphore is set
    a_ts_win_clears: assert property (ts_go && ts_ok |=>
        !($past(ts_cl) ? ts_pend1[$past(ts_cpu)] : ts_pend0[$past(ts_cpu)]) &&
        sem[$past(ts_cl)][$past(ts_sem[ts_cpu])]) else $error("win not applied");
    a_ts_set_retry: assert property (ts_go && !ts_ok |-> !push ##1 ts_req[$past(ts_cpu)])
        else $error("busy semaphore not retried");
    a_ts_load: assert property (acc && i_op_code == OP_TEST_SET && !i_op_cluster |=>
        ts_pend0[$past(i_op_cpu)] && ts_sem[$past(i_op_cpu)] == $past(i_op_sem))
        else $error("test-and-set not loaded");
    a_grp_alternate: assert property (out_take && pick == SRC_LOCAL && ra[3] && rb[3] |->
        sel_b == grp_turn) else $error("group turn ignored");
    c_parity_err: cover property (acc && is_rd && mism);
    c_ts_win: cover property (ts_go && ts_ok);
    c_remote_ret: cover property (out_take && pick == SRC_REMOTE);
    c_broadside: cover property (acc && is_bsr ##[1:40] o_ret_last);
endmodule
`default_nettype wire

// >>> tb/cpu_interface_unit_model.sv
// Model of the CPU interface unit that gathers returned words
`timescale 1ns/1ps
`default_nettype none
module cpu_interface_unit_model (
    // Return port side
    input wire logic i_core_clk,
    input wire logic i_valid,
    input wire logic i_last,
    input wire logic [31:0] i_data,
    input wire logic [5:0] i_cmd,
    input wire logic [3:0] i_steer,
    // Gathered word, command with steering, word count
    output logic [63:0] o_word,
    output logic [9:0] o_tag,
    output int o_count
);
    initial o_count = 0;
    // Low half lands first, the upper half completes the word
    always @(posedge i_core_clk) begin
        if (i_valid && !i_last) o_word[31:0] <= i_data;
        if (i_valid && i_last) begin
            o_word[63:32] <= i_data;
            o_tag <= {i_cmd, i_steer};
            o_count <= o_count + 1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/shared_register_read_return_path_bench.sv
// Testbench for the shared register read return path
`timescale 1ns/1ps
`default_nettype none
module shared_register_read_return_path_bench;
    logic i_core_clk = 0, i_rst_n = 0, v = 0, ill = 0, cl = 0, rv = 0;
    logic [3:0] code = 0, par = 0, rst4 = 0, pflip = 0, slc = 4'h3;
    logic [4:0] cpu = 0;
    logic [5:0] sem = 0, rcmd = 0;
    logic [63:0] d = 0, rd = 0, w;
    logic opr, rr, rv_o, rl;
    logic [31:0] rdat;
    logic [5:0] rc;
    logic [1:0] rcpu, rpath;
    logic [9:0] tag;
    int n, fail_count = 0, compares = 0;
    always #5 i_core_clk = ~i_core_clk;
    shared_register_read_return_path dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_op_valid(v), .o_op_ready(opr), .i_op_code(code), .i_op_cpu(cpu),
        .i_op_slice(slc), .i_op_data(d), .i_op_par(par), .i_op_sem(sem), .i_op_cluster(cl),
        .i_op_mm(1'b0), .i_op_illegal(ill), .i_rmt_valid(rv), .o_rmt_ready(rr),
        .i_rmt_data(rd), .i_rmt_cmd(rcmd), .i_rmt_steer(rst4), .o_ret_valid(rv_o),
        .o_ret_last(rl), .o_ret_data(rdat), .o_ret_cmd(rc), .o_ret_cpu(rcpu),
        .o_ret_path(rpath));
    cpu_interface_unit_model far (.i_core_clk(i_core_clk), .i_valid(rv_o), .i_last(rl),
        .i_data(rdat), .i_cmd(rc), .i_steer({rpath, rcpu}), .o_word(w), .o_tag(tag),
        .o_count(n));
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Offer one operation, hold it until the edge that takes it
    task automatic op(input logic [3:0] c, input logic [4:0] p, input logic [63:0] dt,
                      input logic [5:0] s, input logic il);
        @(negedge i_core_clk);
        code = c; cpu = p; d = dt; sem = s; ill = il; v = 1;
        par = {^dt[63:48], ^dt[47:32], ^dt[31:16], ^dt[15:0]} ^ pflip;
        while (!opr) @(negedge i_core_clk);
        @(negedge i_core_clk);
        v = 0;
    endtask
    // Wait for the next word and compare it, or check that none comes
    task automatic get(input string nm, input logic [63:0] ed, input logic [9:0] et,
                       input bit none);
        int n0, k;
        n0 = n;
        for (k = 0; k < 200 && n == n0; k++) @(negedge i_core_clk);
        if (none) chk({nm, " silent"}, n - n0, 0);
        else begin
            chk({nm, " count"}, n - n0, 1);
            chk({nm, " data"}, w, ed);
            chk({nm, " tag"}, tag, et);
        end
    endtask
    localparam logic [63:0] PAT = 64'hffff_0000_0000_ffdf;
    initial begin
        repeat (10) @(negedge i_core_clk);
        i_rst_n = 1;
        chk("rmt ready", rr, 1);
        op(4'h4, 5'h1b, 64'h0123_4567_89ab_cdef, 0, 0);
        get("read", 64'h0123_4567_89ab_cdef, {6'o44, 4'hf}, 0);
        op(4'h4, 5'h1b, 64'h8000_0000_0000_0001, 0, 0);
        pflip = 4'h2;
        op(4'h4, 5'h12, 64'h0000_0000_0000_0101, 0, 0);
        pflip = 4'h0;
        get("good", 64'h8000_0000_0000_0001, {6'o44, 4'hf}, 0);
        get("parity", 64'h0000_0000_0000_0101, {6'o43, 4'hc}, 0);
        op(4'h4, 5'h01, 64'h0f00, 0, 0);
        get("sorted", 64'h0f00, {6'o44, 4'h1}, 0);
        op(4'h5, 5'h01, 64'h55, 0, 0);
        get("write", 0, 0, 1);
        op(4'h4, 5'h09, 64'h77, 0, 1);
        get("illegal", 0, {6'o44, 4'h3}, 0);
        op(4'hb, 5'h00, PAT, 0, 0);
        op(4'h9, 5'h10, 0, 0, 0);
        get("broadside", PAT, {6'o31, 4'h8}, 0);
        op(4'h7, 5'h02, 0, 0, 0);
        op(4'hc, 5'h02, 0, 6'h05, 0);
        get("ts win", 64'h1, {6'o34, 4'h4}, 0);
        op(4'hc, 5'h02, 0, 6'h05, 0);
        get("ts busy", 0, 0, 1);
        op(4'he, 5'h02, 0, 6'h05, 0);
        get("ts retry", 64'h1, {6'o34, 4'h4}, 0);
        // Both holding groups loaded while the port is busy: group turn decides
        slc = 4'h3;
        op(4'h4, 5'h01, 64'h3, 0, 0);
        slc = 4'h4;
        op(4'h4, 5'h01, 64'h4, 0, 0);
        slc = 4'h7;
        op(4'h4, 5'h01, 64'h7, 0, 0);
        get("grp a", 64'h3, {6'o44, 4'h1}, 0);
        get("grp b", 64'h7, {6'o44, 4'h1}, 0);
        get("grp a2", 64'h4, {6'o44, 4'h1}, 0);
        @(negedge i_core_clk);
        rd = 64'hdead_beef_cafe_f00d; rcmd = 6'o42; rst4 = 4'ha; rv = 1;
        while (!rr) @(negedge i_core_clk);
        @(negedge i_core_clk);
        rv = 0;
        get("remote", 64'hdead_beef_cafe_f00d, {6'o42, 4'hc}, 0);
        wrap_up();
    end
    initial begin
        #200us;
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
